// File: hdl/pcdg_top.sv
// pcdg_top: clock generators, carrier modulators, sandbox path, dead time
// and fault fault_line_a for a three-leg gate drive
// assumes all inputs synchronous to clock_in and config set by software
`timescale 1ns/1ns

module pcdg_top
    import pcdg_pkg::*;
#(
    parameter int NUM_GEN = PCDG_NUM_GEN,
    parameter int NUM_CH = PCDG_NUM_CH
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // clock generators
    input wire pcdg_gen_cfg_type [NUM_GEN-1:0] gen_cfg_in,
    input wire logic sync_in,
    output logic [NUM_GEN-1:0] gen_irq_out,
    output logic [NUM_GEN-1:0] gen_tick_out,
    // sampling clock and averaging
    input wire logic [PCDG_GEN_SEL_W-1:0] adc_gen_sel_in,
    input wire logic avg_disable_in,
    output logic avg_enable_out,
    output logic adc_sample_out,
    // modulators
    input wire pcdg_mod_cfg_type [NUM_CH-1:0] mod_cfg_in,
    input wire logic pwm_enable_in,
    // sandbox path
    input wire logic sandbox_select_in,
    input wire logic sandbox_bypass_in,
    input wire logic [PCDG_NUM_LANE-1:0] sandbox_lanes_in,
    // dead time in clock cycles
    input wire logic [PCDG_DT_W-1:0] dead_time_in,
    input wire logic dead_time_load_in,
    // fault fault_line_a
    input wire logic fault_line_a_in,
    input wire logic internal_fault_in,
    input wire logic fault_clear_in,
    output logic fault_line_a_out,
    output logic fault_active_out,
    // gate lanes
    output logic [PCDG_NUM_LANE-1:0] lanes_out
);
    // ----------------------------------------------------------------
    // clock generators
    // ----------------------------------------------------------------
    logic [NUM_GEN-1:0] tick;
    logic [NUM_GEN-1:0] irq;

    // one instance each so every time base is independent
    for (genvar g = 0; g < NUM_GEN; g++) begin : gen_clk
        pcdg_clock_gen u_gen (
            .clock_in(clock_in),
            .nrst_in(nrst_in),
            .cfg_in(gen_cfg_in[g]),
            .sync_in(sync_in),
            .tick_out(tick[g]),
            .irq_out(irq[g])
        );
    end

    // ----------------------------------------------------------------
    // sampling and averaging
    // ----------------------------------------------------------------
    logic next_avg;
    logic next_sample;

    // averaging only works on the first generator's time base
    always_comb begin
        next_avg = !avg_disable_in
            && (adc_gen_sel_in == PCDG_FIRST_GEN);
        next_sample = tick[adc_gen_sel_in];
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avg_enable_out <= 1'b1; // on by default
            adc_sample_out <= 1'b0;
            gen_irq_out <= '0;
            gen_tick_out <= '0;
        end else begin
            avg_enable_out <= next_avg;
            adc_sample_out <= next_sample;
            gen_irq_out <= irq;
            gen_tick_out <= tick;
        end
    end

    // ----------------------------------------------------------------
    // carrier modulators
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0][PCDG_CNT_W-1:0] car;
    logic [NUM_CH-1:0][PCDG_CNT_W-1:0] next_car;
    logic [NUM_CH-1:0] dir_down;
    logic [NUM_CH-1:0] next_dir_down;
    logic [NUM_CH-1:0][PCDG_CNT_W-1:0] duty;
    logic [NUM_CH-1:0][PCDG_CNT_W-1:0] next_duty;
    logic [NUM_CH-1:0] mod_hi;
    logic [NUM_CH-1:0] next_mod_hi;

    // the carrier steps each tick of its generator; a saw period is 65536
    // ticks, a triangle 131070; phase offsets compare point; duty is shadowed
    always_comb begin
        next_car = car;
        next_dir_down = dir_down;
        next_duty = duty;
        next_mod_hi = mod_hi;
        for (int c = 0; c < NUM_CH; c++) begin
            if (tick[mod_cfg_in[c].gen_sel]) begin
                next_car[c] = car[c] + PCDG_CNT_ONE; // 16-bit
                case (mod_cfg_in[c].carrier) // four shapes
                    PCDG_CAR_SAW_UP, PCDG_CAR_SAW_DOWN: begin
                        next_dir_down[c] = 1'b0;
                        // saw reloads once, at the wrap
                        if (car[c] == '1) begin
                            next_duty[c] = mod_cfg_in[c].duty;
                        end
                    end
                    PCDG_CAR_TRI, PCDG_CAR_TRI_INV: begin
                        if (!dir_down[c] && car[c] == '1) begin
                            next_dir_down[c] = 1'b1;
                            next_car[c] = car[c] - PCDG_CNT_ONE;
                            // double rate also loads at the peak
                            if (mod_cfg_in[c].double_update) begin
                                next_duty[c] = mod_cfg_in[c].duty;
                            end
                        end else if (dir_down[c]) begin
                            next_car[c] = car[c] - PCDG_CNT_ONE;
                            if (car[c] == PCDG_CNT_ONE) begin
                                next_dir_down[c] = 1'b0;
                                next_duty[c] = mod_cfg_in[c].duty;
                            end
                        end
                    end
                    default: begin
                        next_dir_down[c] = 1'b0;
                    end
                endcase
            end
            case (mod_cfg_in[c].carrier)
                PCDG_CAR_SAW_DOWN, PCDG_CAR_TRI_INV: begin
                    next_mod_hi[c] =
                        (PCDG_CNT_W'(car[c] + mod_cfg_in[c].phase)) >= duty[c];
                end
                default: begin
                    next_mod_hi[c] =
                        (PCDG_CNT_W'(car[c] + mod_cfg_in[c].phase)) < duty[c];
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            car <= '0;
            dir_down <= '0;
            duty <= '0;
            mod_hi <= '0;
        end else begin
            car <= next_car;
            dir_down <= next_dir_down;
            duty <= next_duty;
            mod_hi <= next_mod_hi;
        end
    end

    // ----------------------------------------------------------------
    // source select and dead time
    // ----------------------------------------------------------------
    logic [PCDG_DT_W-1:0] dead_time;
    logic [PCDG_DT_W-1:0] next_dead_time;
    logic [PCDG_NUM_LANE-1:0] src;
    logic [PCDG_NUM_LANE-1:0] dt_lanes;
    logic [PCDG_NUM_LANE-1:0] pre_lanes;

    // dead time is held so a mid-pulse input change cannot shorten it
    always_comb begin
        next_dead_time = dead_time;
        if (dead_time_load_in) begin
            next_dead_time = (dead_time_in == PCDG_DT_ZERO) ?
                PCDG_DT_ONE : dead_time_in; // at least one step
        end
        for (int c = 0; c < NUM_CH; c++) begin
            // complementary pair of the modulator
            src[2*c] = sandbox_select_in ? sandbox_lanes_in[2*c] : mod_hi[c];
            src[2*c+1] = sandbox_select_in ? sandbox_lanes_in[2*c+1]
                : !mod_hi[c];
        end
        // bypass only for the sandbox source
        pre_lanes = (sandbox_select_in && sandbox_bypass_in) ?
            sandbox_lanes_in : dt_lanes;
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dead_time <= PCDG_DT_RESET; // default
        end else begin
            dead_time <= next_dead_time;
        end
    end

    for (genvar p = 0; p < NUM_CH; p++) begin : gen_dt
        pcdg_dead_time u_dt (
            .clock_in(clock_in),
            .nrst_in(nrst_in),
            .hi_in(src[2*p]),
            .lo_in(src[2*p+1]),
            .dt_in(dead_time),
            .hi_out(dt_lanes[2*p]),
            .lo_out(dt_lanes[2*p+1])
        );
    end

    // ----------------------------------------------------------------
    // fault fault_line_a and lane drive
    // ----------------------------------------------------------------
    logic fault;
    logic next_fault;
    logic [PCDG_NUM_LANE-1:0] next_lanes;

    // a fault arriving with the clear wins, so none is lost
    always_comb begin
        next_fault = fault;
        if (fault_clear_in) begin
            next_fault = 1'b0;
        end
        if (fault_line_a_in || internal_fault_in) begin
            next_fault = 1'b1;
        end
        next_lanes = pre_lanes;
        if (next_fault || !pwm_enable_in) begin
            next_lanes = '0;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fault <= 1'b0;
            fault_active_out <= 1'b0;
            fault_line_a_out <= 1'b0;
            lanes_out <= '0;
        end else begin
            fault <= next_fault;
            fault_active_out <= next_fault;
            fault_line_a_out <= internal_fault_in; // tell others
            lanes_out <= next_lanes;
        end
    end

    a_fault_blocks: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (fault_line_a_in || internal_fault_in) |=> lanes_out == '0)
        else $error("lanes not blocked on fault");
    a_fault_holds: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (fault && !fault_clear_in) |=> fault_active_out && lanes_out == '0)
        else $error("fault released without clear");
    a_avg_first: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (adc_gen_sel_in != PCDG_FIRST_GEN) |=> !avg_enable_out)
        else $error("averaging on other generator");
    a_fault_out: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        internal_fault_in |=> fault_line_a_out)
        else $error("internal fault not signalled");
    a_dt_floor: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        dead_time != PCDG_DT_ZERO)
        else $error("dead time zero");
    // lanes fed through the dead-time stage never close both switches
    // of one leg; only the sandbox bypass is left to the user
    a_leg_exclusive: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        !$past(sandbox_select_in && sandbox_bypass_in)
        |-> (lanes_out[1:0] != 2'h3 && lanes_out[3:2] != 2'h3
            && lanes_out[5:4] != 2'h3))
        else $error("both switches of a leg on");
    // the sampling strobe follows the selected generator's tick
    a_sample_sel: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        $stable(adc_gen_sel_in)
        |-> adc_sample_out == gen_tick_out[adc_gen_sel_in])
        else $error("sample strobe off its generator");
    // an interrupt pulse only ever comes with its period tick
    a_irq_with_tick: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (gen_irq_out & ~gen_tick_out) == '0)
        else $error("interrupt without tick");
endmodule : pcdg_top

// File: hdl/pcdg_pkg.sv
// pcdg_pkg: shared constants and carriers for the pwm clock/dead-time block
// assumes a single 50 MHz clock; all timing is counted in clock_in cycles
package pcdg_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int PCDG_NUM_GEN = 4;
    localparam int PCDG_NUM_CH = 3;
    localparam int PCDG_NUM_LANE = 6;
    localparam int PCDG_CNT_W = 16;
    localparam int PCDG_POST_W = 12;
    localparam int PCDG_DT_W = 17;
    localparam int PCDG_GEN_SEL_W = 2;
    localparam int PCDG_CAR_W = 2;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int PCDG_CLK_PERIOD_NS = 20;
    localparam int PCDG_DT_DEFAULT_NS = 124;
    // least time rounds up to whole cycles
    localparam int PCDG_DT_DEFAULT_CYC =
        (PCDG_DT_DEFAULT_NS + PCDG_CLK_PERIOD_NS - 1) / PCDG_CLK_PERIOD_NS;
    localparam logic [PCDG_DT_W-1:0] PCDG_DT_RESET =
        PCDG_DT_W'(PCDG_DT_DEFAULT_CYC);
    localparam logic [PCDG_CNT_W-1:0] PCDG_CNT_ZERO = 16'h0000;
    localparam logic [PCDG_CNT_W-1:0] PCDG_CNT_ONE = 16'h0001;
    localparam logic [PCDG_POST_W-1:0] PCDG_POST_ZERO = 12'h000;
    localparam logic [PCDG_POST_W-1:0] PCDG_POST_ONE = 12'h001;
    localparam logic [PCDG_DT_W-1:0] PCDG_DT_ZERO = 17'h00000;
    localparam logic [PCDG_DT_W-1:0] PCDG_DT_ONE = 17'h00001;
    localparam logic [PCDG_GEN_SEL_W-1:0] PCDG_FIRST_GEN = 2'h0;
    // ----------------------------------------------------------------
    // carrier shapes
    // ----------------------------------------------------------------
    typedef enum logic [PCDG_CAR_W-1:0] {
        PCDG_CAR_SAW_UP,
        PCDG_CAR_SAW_DOWN,
        PCDG_CAR_TRI,
        PCDG_CAR_TRI_INV
    } pcdg_carrier_type;
    // clock generator configuration, taken at the end of each period
    typedef struct packed {
        logic [PCDG_CNT_W-1:0] prescale;
        logic [PCDG_CNT_W-1:0] period;
        logic [PCDG_POST_W-1:0] postscale;
    } pcdg_gen_cfg_type;
    // modulator parameters
    typedef struct packed {
        logic [PCDG_CNT_W-1:0] duty;
        logic [PCDG_CNT_W-1:0] phase;
        pcdg_carrier_type carrier;
        logic double_update;
        logic [PCDG_GEN_SEL_W-1:0] gen_sel;
    } pcdg_mod_cfg_type;
endpackage : pcdg_pkg

// File: hdl/pcdg_clock_gen.sv
// pcdg_clock_gen: one clock generator (prescaler, period, postscaler)
// assumes config inputs are static or change only between pulses
`timescale 1ns/1ns
module pcdg_clock_gen
    import pcdg_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // configuration
    input wire pcdg_gen_cfg_type cfg_in,
    input wire logic sync_in,
    // time base outputs
    output logic tick_out,
    output logic irq_out
);
    pcdg_gen_cfg_type act;
    pcdg_gen_cfg_type next_act;
    logic [PCDG_CNT_W-1:0] pre;
    logic [PCDG_CNT_W-1:0] next_pre;
    logic [PCDG_CNT_W-1:0] cnt;
    logic [PCDG_CNT_W-1:0] next_cnt;
    logic [PCDG_POST_W-1:0] post;
    logic [PCDG_POST_W-1:0] next_post;
    logic next_tick;
    logic next_irq;

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    // new settings are only taken at the period wrap so no short pulse
    always_comb begin
        next_act = act;
        next_pre = pre + PCDG_CNT_ONE;
        next_cnt = cnt;
        next_post = post;
        next_tick = 1'b0;
        next_irq = 1'b0;
        if (sync_in) begin // phase align to the master
            next_pre = PCDG_CNT_ZERO;
            next_cnt = PCDG_CNT_ZERO;
            next_post = PCDG_POST_ZERO;
        end else if (pre >= act.prescale) begin // 16-bit prescaler
            next_pre = PCDG_CNT_ZERO;
            next_cnt = cnt + PCDG_CNT_ONE;
            if (cnt >= act.period) begin
                next_cnt = PCDG_CNT_ZERO;
                next_tick = 1'b1; // pwm reference
                next_act = cfg_in; // glitch-free reload
                if (post >= act.postscale) begin // 0..4095
                    next_post = PCDG_POST_ZERO;
                    next_irq = 1'b1; // interrupt request
                end else begin
                    next_post = post + PCDG_POST_ONE;
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            act <= '0;
            pre <= PCDG_CNT_ZERO;
            cnt <= PCDG_CNT_ZERO;
            post <= PCDG_POST_ZERO;
            tick_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            act <= next_act;
            pre <= next_pre;
            cnt <= next_cnt;
            post <= next_post;
            tick_out <= next_tick;
            irq_out <= next_irq;
        end
    end

    // a reload must not squeeze in an extra pulse; only a one-cycle
    // period may tick on back-to-back cycles
    a_tick_single: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        tick_out && (act.prescale != PCDG_CNT_ZERO
            || act.period != PCDG_CNT_ZERO) |=> !tick_out)
        else $error("tick longer than one cycle");
    a_irq_on_tick: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        irq_out |-> tick_out)
        else $error("irq without period tick");
endmodule : pcdg_clock_gen

// File: hdl/pcdg_dead_time.sv
// pcdg_dead_time: dead-time insertion for one high/low lane pair
// assumes hi/lo requests are synchronous; only rising edges are delayed
`timescale 1ns/1ns
module pcdg_dead_time
    import pcdg_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // pair request and dead time in cycles
    input wire logic hi_in,
    input wire logic lo_in,
    input wire logic [PCDG_DT_W-1:0] dt_in,
    // gated pair
    output logic hi_out,
    output logic lo_out
);
    logic [PCDG_DT_W-1:0] cnt_hi;
    logic [PCDG_DT_W-1:0] next_cnt_hi;
    logic [PCDG_DT_W-1:0] cnt_lo;
    logic [PCDG_DT_W-1:0] next_cnt_lo;
    logic next_hi;
    logic next_lo;

    // ----------------------------------------------------------------
    // rising edge delay
    // ----------------------------------------------------------------
    // a request must hold for dt cycles before the output rises, so a
    // pulse shorter than the dead time never appears
    always_comb begin
        next_cnt_hi = PCDG_DT_ZERO;
        next_cnt_lo = PCDG_DT_ZERO;
        next_hi = 1'b0;
        next_lo = 1'b0;
        if (hi_in && !lo_in) begin
            if (cnt_hi >= dt_in) begin
                next_hi = 1'b1; // delayed rise
                next_cnt_hi = cnt_hi;
            end else begin
                next_cnt_hi = cnt_hi + PCDG_DT_ONE;
            end
        end
        if (lo_in && !hi_in) begin
            if (cnt_lo >= dt_in) begin
                next_lo = 1'b1; // delayed rise
                next_cnt_lo = cnt_lo;
            end else begin
                next_cnt_lo = cnt_lo + PCDG_DT_ONE;
            end
        end
    end

    // falls pass after one register stage, undelayed by the dead time
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_hi <= PCDG_DT_ZERO;
            cnt_lo <= PCDG_DT_ZERO;
            hi_out <= 1'b0;
            lo_out <= 1'b0;
        end else begin
            cnt_hi <= next_cnt_hi;
            cnt_lo <= next_cnt_lo;
            hi_out <= next_hi;
            lo_out <= next_lo;
        end
    end

    a_no_overlap: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        !(hi_out && lo_out))
        else $error("both sides on");
    a_fall_fast: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (hi_out && !hi_in) |=> !hi_out)
        else $error("fall delayed");
    a_rise_wait: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        $rose(hi_out) |-> $past(cnt_hi) >= $past(dt_in))
        else $error("rise before dead time");
endmodule : pcdg_dead_time

// File: bench/pcdg_gate_model.sv
// pcdg_gate_model: gate driver side of the three gate legs
// assumes lanes are sampled on clock_in; trip is commanded by the bench
`timescale 1ns/1ns
module pcdg_gate_model
    import pcdg_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // gate lanes and trip command
    input wire logic [PCDG_NUM_LANE-1:0] lanes_in,
    input wire logic trip_in,
    // fault line toward the device, shoot-through flag
    output logic fault_line_a_out,
    output logic shoot_out
);
    // ----------------------------------------------------------------
    // fault line and leg watch
    // ----------------------------------------------------------------
    // external trip raised straight onto the fault_line_a line
    assign fault_line_a_out = trip_in;
    // sticky: a leg with both switches on is never forgiven
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shoot_out <= 1'b0;
        end else if (|(lanes_in[0+:6] & {lanes_in[4+:2], lanes_in[0+:4]}
                       & 6'h2a & {lanes_in[0+:5], 1'b0})) begin
            shoot_out <= 1'b1;
        end
    end
endmodule : pcdg_gate_model

// File: bench/tb_pcdg_top.sv
// tb_pcdg_top: self-checking bench for the gate drive block
// assumes the gate model on the lanes; inputs move 1 ns after rising edge
`timescale 1ns/1ns
module tb_pcdg_top;
    import pcdg_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk = 0, nrst = 0, sync = 0, adis = 0, pen = 0, ssel = 0;
    logic sbyp = 0, dtld = 0, ifault = 0, fclr = 0, trip = 0, xfault, shoot;
    logic [1:0] asel = 0;
    logic [5:0] slanes = 0, lanes, acc;
    logic [16:0] dt = 0;
    pcdg_gen_cfg_type [3:0] gcfg = '0;
    pcdg_mod_cfg_type [2:0] mcfg = '0;
    logic [3:0] irq, tick;
    logic aen, asmp, xout, fact;
    int err_count = 0, num_checks = 0, n, k, p, q, s, dv;
    logic [31:0] seed = 32'h0000004e; // xorshift start value 78
    pcdg_top pcdg_top_inst (.clock_in(clk), .nrst_in(nrst),
        .gen_cfg_in(gcfg), .sync_in(sync), .gen_irq_out(irq),
        .gen_tick_out(tick), .adc_gen_sel_in(asel), .avg_disable_in(adis),
        .avg_enable_out(aen), .adc_sample_out(asmp), .mod_cfg_in(mcfg),
        .pwm_enable_in(pen), .sandbox_select_in(ssel),
        .sandbox_bypass_in(sbyp), .sandbox_lanes_in(slanes),
        .dead_time_in(dt), .dead_time_load_in(dtld),
        .fault_line_a_in(xfault), .internal_fault_in(ifault),
        .fault_clear_in(fclr), .fault_line_a_out(xout),
        .fault_active_out(fact), .lanes_out(lanes));
    pcdg_gate_model pcdg_gate_model_inst (.clock_in(clk), .nrst_in(nrst),
        .lanes_in(lanes), .trip_in(trip), .fault_line_a_out(xfault),
        .shoot_out(shoot));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // clock at 50 MHz
    initial forever #10 clk = ~clk;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // zero duty: rising carriers close the low sides all period, falling
    // ones compare the other way round and close the high sides
    function logic [5:0] zero_duty_lanes(input int shape);
        if (shape == PCDG_CAR_SAW_DOWN || shape == PCDG_CAR_TRI_INV) begin
            return 6'h15;
        end
        return 6'h2a;
    endfunction : zero_duty_lanes
    task finish_test;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // inputs always change 1 ns past the edge
    task step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : step
    task wait_tick(input int g, output int c);
        c = 0;
        do begin step(1); c++; end while (tick[g] !== 1'b1 && c < 200);
    endtask : wait_tick
    // drive sandbox lanes, count edges until lane idx goes high
    task rise(input int idx, input logic [5:0] v, input int exp);
        n = 0;
        slanes = v;
        while (lanes[idx] !== 1'b1 && n < 400) begin step(1); n++; end
        check(n, exp);
        slanes = 6'h00;
        step(2);
        check(lanes, 6'h00);
    endtask : rise
    // watchdog at 20000 cycles; whole run is under a thousand cycles
    initial begin
        #400000;
        err_count++;
        finish_test;
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        step(4);
        check({lanes, aen, fact}, 8'h02);
        nrst = 1;
        $display("test reset done");
        // every generator, random small counts
        for (int g = 0; g < 4; g++) begin
            p = rnd() % 3; q = rnd() % 4; s = rnd() % 3;
            gcfg[g].prescale = 16'(p);
            gcfg[g].period = 16'(q);
            gcfg[g].postscale = 12'(s);
            repeat (3) wait_tick(g, n);
            wait_tick(g, n);
            check(n, (p + 1) * (q + 1));
            // first pass finds an interrupt, second counts ticks to the next
            repeat (2) begin
                k = 0;
                do begin
                    wait_tick(g, n);
                    k++;
                end while (irq[g] !== 1'b1 && k < 9);
            end
            check(k, s + 1);
        end
        // realign two equal generators
        gcfg[1] = gcfg[0];
        step(20);
        sync = 1;
        step(1);
        sync = 0;
        repeat (12) begin step(1); check(tick[1], tick[0]); end
        $display("test generators done");
        asel = 2'h2; step(3); check(aen, 1'b0);
        // the sampling strobe must follow the newly selected generator
        repeat (12) begin
            step(1);
            check(asmp, tick[2]);
        end
        asel = 2'h0; step(3); check(aen, 1'b1);
        adis = 1; step(3); check(aen, 1'b0);
        $display("test averaging done");
        // sandbox lanes through dead time
        pen = 1; ssel = 1; step(12);
        rise(0, 6'h01, PCDG_DT_DEFAULT_CYC + 2);
        dv = rnd() % 5 + 3;
        dt = 17'(dv);
        dtld = 1;
        step(1);
        dtld = 0;
        step(2);
        // low side of every leg, each on its own lane
        for (int c = 0; c < 3; c++) begin
            rise(2 * c + 1, 6'(2 << (2 * c)), dv + 2);
        end
        slanes = 6'h04; step(dv - 1); slanes = 6'h00; acc = 0;
        repeat (dv + 4) begin step(1); acc |= lanes; end
        check(acc, 6'h00);
        slanes = 6'h03; step(dv + 4); check(lanes, 6'h00);
        slanes = 6'h00; step(3); check(shoot, 1'b0);
        sbyp = 1; slanes = 6'(rnd()); step(3); check(lanes, slanes);
        $display("test dead time done");
        // modulators at zero duty, bypass still set but ignored
        ssel = 0;
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < 3; i++) begin
                mcfg[i].carrier = pcdg_carrier_type'(c);
            end
            mcfg[0].double_update = c[0];
            step(30);
            check(lanes, zero_duty_lanes(c));
        end
        pen = 0; step(3); check(lanes, 6'h00);
        pen = 1; step(30);
        $display("test modulators done");
        // external trip, clear refused while a fault stands
        trip = 1; step(1); check({lanes, fact}, 7'h01);
        trip = 0; ifault = 1; fclr = 1; step(1); check(xout, 1'b1);
        step(1); check({lanes, fact}, 7'h01);
        ifault = 0; fclr = 0; step(1); fclr = 1; step(1); fclr = 0;
        check({xout, fact}, 2'h0);
        step(30); check(lanes, zero_duty_lanes(PCDG_CAR_TRI_INV));
        $display("test fault done");
        finish_test;
    end
endmodule : tb_pcdg_top
